// ### src/uart_rx_regs.svh
// Purpose: Register offsets, field positions and reset values of the
//          receive status block.
// Assumes: Included by its bare name from the design files.
// Notes:   Definitions only.
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CTRL_OFS 4'h0
`define BAUD_OFS 4'h1
`define STATUS_OFS 4'h2
`define DATA_OFS 4'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_EN_BIT 0
`define CTRL_FORM_LSB 1
`define CTRL_PINOUT_LSB 5
`define CTRL_ODD_BIT 7
`define PAR_ERR_BIT 0
`define FRM_ERR_BIT 1
`define OVF_BIT 2
`define CTS_BIT 3
`define DRDY_BIT 4

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define FORM_PAR_A 4'h1
`define FORM_PAR_B 4'h5
`define FORM_PAR_C 4'h7
`define PINOUT_FLOW 2'h2
`define BAUD_RESET 16'h043D
`define SYNC_RESET 2'h3
`define FIFO_DEPTH 8

`endif

// ### src/uart_rx_pkg.sv
// Purpose: Types shared by the receive status block.
// Assumes: Nothing.
// Notes:   Types only; constants sit in the register header.
package uart_rx_pkg;

	// ****************************************************************
	// Receiver sequencer states, one-hot
	// ****************************************************************
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PARITY = 5'h08,
		RX_STOP = 5'h10
	} rx_state_t;

	// ****************************************************************
	// One received character with its error marks
	// ****************************************************************
	typedef struct packed {
		logic frame_bad; // Stop bit sampled low
		logic parity_bad; // Parity mismatch under a parity format
		logic [7:0] data;
	} char_t;

endpackage

// ### src/rx_fifo_if.sv
// Purpose: Carrier between the receiver and its character buffer.
// Assumes: One clock shared by both ends.
// Notes:   Valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
interface rx_fifo_if #(parameter int WIDTH = 10);
	logic push_valid; // Character offered
	logic push_ready; // Buffer has room
	logic [WIDTH-1:0] push_data; // Character written
	logic pop_valid; // Buffer holds a character
	logic pop_ready; // Reader takes the head
	logic [WIDTH-1:0] pop_data; // Head character
	logic flush; // Empty the buffer
	modport user (output push_valid, push_data, pop_ready, flush,
		input push_ready, pop_valid, pop_data);
	modport store (input push_valid, push_data, pop_ready, flush,
		output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// ### src/rx_fifo.sv
// Purpose: Character buffer between receiver and data register.
// Assumes: Writer honours push_ready; reader honours pop_valid.
// Notes:   Flush empties the buffer in one cycle.
`timescale 1ns/1ns
`default_nettype none
module rx_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	rx_fifo_if.store port
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage entries
		logic [PW-1:0] wr_ptr; // Next entry to fill
		logic [PW-1:0] rd_ptr; // Head entry
		logic [PW:0] count; // Entries in use
	} fifo_state_t;

	fifo_state_t state;
	fifo_state_t next_state;
	logic do_push;
	logic do_pop;

	// Honest flags straight from the count
	assign port.push_ready = (state.count != FULL);
	assign port.pop_valid = (state.count != '0);
	assign port.pop_data = state.mem[state.rd_ptr];

	// Pointer and count update
	always_comb begin
		next_state = state;
		do_push = port.push_valid && port.push_ready;
		do_pop = port.pop_ready && port.pop_valid;
		if (do_push) begin
			next_state.mem[state.wr_ptr] = port.push_data;
			next_state.wr_ptr = state.wr_ptr + 1'b1;
		end
		if (do_pop) begin
			next_state.rd_ptr = state.rd_ptr + 1'b1;
		end
		if (do_push && !do_pop) begin
			next_state.count = state.count + 1'b1;
		end else if (do_pop && !do_push) begin
			next_state.count = state.count - 1'b1;
		end
		if (port.flush) begin
			next_state.wr_ptr = '0;
			next_state.rd_ptr = '0;
			next_state.count = '0;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
endmodule
`default_nettype wire

// ### src/pin_sync.sv
// Purpose: Three-stage synchroniser for the line pins.
// Assumes: Pins are asynchronous to ref_clk.
// Notes:   A high counts once stages two and three agree; a low counts as soon as either is low.
`timescale 1ns/1ns
`default_nettype none
`include "uart_rx_regs.svh"
module pin_sync (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [1:0] pin_in,
	output logic [1:0] level
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [1:0] s1; // Metastable stage, read only by s2
		logic [1:0] s2; // Second stage
		logic [1:0] s3; // Third stage
		logic [1:0] lvl; // Accepted level
	} sync_state_t;

	sync_state_t state;
	sync_state_t next_state;

	assign level = state.lvl;

	// Shift and accept agreed bits
	always_comb begin
		next_state = state;
		next_state.s1 = pin_in;
		next_state.s2 = state.s1;
		next_state.s3 = state.s2;
		next_state.lvl = (state.s2 & state.s3) |
			(state.lvl & ~(state.s2 ^ state.s3));
	end

	// State register, lines idle high
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= {`SYNC_RESET, `SYNC_RESET, `SYNC_RESET, `SYNC_RESET};
		end else begin
			state <= next_state;
		end
	end
endmodule
`default_nettype wire

// ### src/uart_rx_error_status.sv
// Purpose: Serial receiver with error and line status flags.
// Assumes: Register master per plain strobe port; pins asynchronous.
// Notes:   Framing and parity errors travel with each buffered character.
// Function
// RQ1: Status bit 3 shows CTS under flow control
// RQ2: Writes never change the CTS status bit
// RQ3: Overflow when buffer full, char waiting, start
// RQ4: Framing error when first stop bit zero
// RQ5: Parity error only for parity-enabled formats
// RQ6: Writing one clears an error flag
// RQ7: Writing zero leaves error flags unchanged
// RQ8: Disabling receiver clears all error flags
// RQ9: Flags describe the character read next
// RQ10: Errors buffered with character, loaded with it
`timescale 1ns/1ns
`default_nettype none
`include "uart_rx_regs.svh"
module uart_rx_error_status (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic rx_pin,
	input wire logic cts_pin,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic rx_enable; // Receiver on
		logic [3:0] frame_format_select; // Character format
		logic [1:0] transmit_pinout_select; // Pin use, flow control
		logic parity_odd; // Odd parity when set
		logic [15:0] baud; // Clock cycles per bit
		uart_rx_pkg::rx_state_t rx; // Receiver sequencer
		logic [15:0] cnt; // Cycles to next sample
		logic [2:0] bitn; // Data bit index
		logic [7:0] shift; // Receive shift register
		logic par_bad; // Parity mismatch of current char
		logic pend_valid; // Character waiting for buffer
		uart_rx_pkg::char_t pend; // Waiting character
		logic data_valid; // Data register holds a char
		uart_rx_pkg::char_t dreg; // Receive data register
		logic receive_overflow_flag; // Sticky overflow
		logic framing_error_flag; // Sticky framing error
		logic parity_error_flag; // Sticky parity error
		logic [15:0] rdata; // Read data, one cycle
	} main_state_t;

	main_state_t state;
	main_state_t next_state;
	logic [1:0] line_level; // Synchronised {cts, rx}
	logic rx_level; // Receive line
	logic cts_level; // Clear-to-send line
	logic flow_en; // Hardware flow control selected
	logic parity_en; // Format carries parity
	logic start_det; // Start edge seen while idle
	logic stop_done; // Stop bit sampled
	logic stop_take; // Completed char accepted
	logic ovf_set; // Overflow event
	logic load; // Head moves into data register
	logic data_rd; // Software reads data register
	logic status_wr; // Software writes status
	logic status_rd; // Software reads status
	logic [2:0] err_flags; // {overflow, framing, parity}
	uart_rx_pkg::char_t head; // Buffer head

	rx_fifo_if #(.WIDTH($bits(uart_rx_pkg::char_t))) fifo ();

	// ****************************************************************
	// Line synchroniser and buffer
	// ****************************************************************
	pin_sync u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pin_in({cts_pin, rx_pin}),
		.level(line_level)
	);

	rx_fifo #(
		.WIDTH($bits(uart_rx_pkg::char_t)),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.port(fifo.store)
	);

	assign rx_level = line_level[0];
	assign cts_level = line_level[1];
	assign reg_rdata = state.rdata;
	assign err_flags = {state.receive_overflow_flag,
		state.framing_error_flag, state.parity_error_flag};
	assign head = uart_rx_pkg::char_t'(fifo.pop_data);

	// Buffer handshakes
	assign fifo.push_valid = state.pend_valid;
	assign fifo.push_data = state.pend;
	assign fifo.pop_ready = load;
	assign fifo.flush = !state.rx_enable;

	// ****************************************************************
	// Decode and events
	// ****************************************************************
	always_comb begin
		flow_en = (state.transmit_pinout_select == `PINOUT_FLOW);
		parity_en = (state.frame_format_select == `FORM_PAR_A) ||
			(state.frame_format_select == `FORM_PAR_B) ||
			(state.frame_format_select == `FORM_PAR_C);
		status_wr = reg_wr && (reg_addr == `STATUS_OFS);
		status_rd = reg_rd && (reg_addr == `STATUS_OFS);
		data_rd = reg_rd && (reg_addr == `DATA_OFS);
		start_det = state.rx_enable && (state.rx == uart_rx_pkg::RX_IDLE) &&
			!rx_level;
		stop_done = state.rx_enable && (state.rx == uart_rx_pkg::RX_STOP) &&
			(state.cnt == 16'h0000);
		// A full buffer with a char still waiting drops the new one
		stop_take = stop_done && (!state.pend_valid || fifo.push_ready);
		ovf_set = start_det && state.pend_valid && !fifo.push_ready; // RQ3
		// Refill the data register when empty or being read
		load = state.rx_enable && fifo.pop_valid &&
			(!state.data_valid || data_rd); // RQ9
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_state = state;
		next_state.rdata = 16'h0000;

		// Control and baud writes
		if (reg_wr && (reg_addr == `CTRL_OFS)) begin
			next_state.rx_enable = reg_wdata[`CTRL_EN_BIT];
			next_state.frame_format_select =
				reg_wdata[`CTRL_FORM_LSB +: 4];
			next_state.transmit_pinout_select =
				reg_wdata[`CTRL_PINOUT_LSB +: 2];
			next_state.parity_odd = reg_wdata[`CTRL_ODD_BIT];
		end
		if (reg_wr && (reg_addr == `BAUD_OFS)) begin
			next_state.baud = reg_wdata;
		end

		// Receiver sequencer, samples mid-bit
		unique case (state.rx)
			uart_rx_pkg::RX_IDLE: begin
				// Start edge: wait half a bit then check
				if (start_det) begin
					next_state.rx = uart_rx_pkg::RX_START;
					next_state.cnt = {1'b0, state.baud[15:1]};
				end
			end
			uart_rx_pkg::RX_START: begin
				if (state.cnt == 16'h0000) begin
					// False start returns to idle
					if (!rx_level) begin
						next_state.rx = uart_rx_pkg::RX_DATA;
						next_state.cnt = state.baud - 16'h0001;
						next_state.bitn = 3'h0;
					end else begin
						next_state.rx = uart_rx_pkg::RX_IDLE;
					end
				end else begin
					next_state.cnt = state.cnt - 16'h0001;
				end
			end
			uart_rx_pkg::RX_DATA: begin
				if (state.cnt == 16'h0000) begin
					// LSB first
					next_state.shift = {rx_level, state.shift[7:1]};
					next_state.cnt = state.baud - 16'h0001;
					next_state.bitn = state.bitn + 3'h1;
					if (state.bitn == 3'h7) begin
						next_state.rx = parity_en ? uart_rx_pkg::RX_PARITY :
							uart_rx_pkg::RX_STOP;
					end
				end else begin
					next_state.cnt = state.cnt - 16'h0001;
				end
			end
			uart_rx_pkg::RX_PARITY: begin
				if (state.cnt == 16'h0000) begin
					// Mismatch against selected sense
					next_state.par_bad =
						((^{state.shift, rx_level}) != state.parity_odd);
					next_state.rx = uart_rx_pkg::RX_STOP;
					next_state.cnt = state.baud - 16'h0001;
				end else begin
					next_state.cnt = state.cnt - 16'h0001;
				end
			end
			uart_rx_pkg::RX_STOP: begin
				if (state.cnt == 16'h0000) begin
					next_state.rx = uart_rx_pkg::RX_IDLE;
					next_state.par_bad = 1'b0;
				end else begin
					next_state.cnt = state.cnt - 16'h0001;
				end
			end
		endcase

		// Waiting character leaves for the buffer
		if (state.pend_valid && fifo.push_ready) begin
			next_state.pend_valid = 1'b0;
		end
		// Completed character with its error marks
		if (stop_take) begin
			next_state.pend_valid = 1'b1;
			next_state.pend.data = state.shift;
			next_state.pend.frame_bad = !rx_level; // RQ4
			next_state.pend.parity_bad = parity_en && state.par_bad; // RQ5
		end

		// Data register read and refill
		if (data_rd) begin
			next_state.rdata = {8'h00, state.dreg.data};
			next_state.data_valid = 1'b0;
		end
		if (load) begin
			next_state.data_valid = 1'b1;
			next_state.dreg = head; // RQ10
		end

		// Status read; CTS is live, never stored
		if (status_rd) begin
			next_state.rdata[`PAR_ERR_BIT] = state.parity_error_flag;
			next_state.rdata[`FRM_ERR_BIT] = state.framing_error_flag;
			next_state.rdata[`OVF_BIT] = state.receive_overflow_flag;
			next_state.rdata[`CTS_BIT] = flow_en && cts_level; // RQ1 RQ2
			next_state.rdata[`DRDY_BIT] = state.data_valid;
		end
		if (reg_rd && (reg_addr == `CTRL_OFS)) begin
			next_state.rdata[`CTRL_EN_BIT] = state.rx_enable;
			next_state.rdata[`CTRL_FORM_LSB +: 4] = state.frame_format_select;
			next_state.rdata[`CTRL_PINOUT_LSB +: 2] =
				state.transmit_pinout_select;
			next_state.rdata[`CTRL_ODD_BIT] = state.parity_odd;
		end
		if (reg_rd && (reg_addr == `BAUD_OFS)) begin
			next_state.rdata = state.baud;
		end

		// Error flags: one clears, zero keeps
		if (status_wr) begin
			if (reg_wdata[`OVF_BIT]) begin
				next_state.receive_overflow_flag = 1'b0; // RQ6 RQ7
			end
			if (reg_wdata[`FRM_ERR_BIT]) begin
				next_state.framing_error_flag = 1'b0; // RQ6 RQ7
			end
			if (reg_wdata[`PAR_ERR_BIT]) begin
				next_state.parity_error_flag = 1'b0; // RQ6 RQ7
			end
		end
		// Events win over a clear in the same cycle
		if (ovf_set) begin
			next_state.receive_overflow_flag = 1'b1; // RQ3
		end
		if (load && head.frame_bad) begin
			next_state.framing_error_flag = 1'b1; // RQ9 RQ10
		end
		if (load && head.parity_bad) begin
			next_state.parity_error_flag = 1'b1; // RQ9 RQ10
		end

		// Receiver off: flags, sequencer and held chars cleared
		if (!state.rx_enable) begin
			next_state.receive_overflow_flag = 1'b0; // RQ8
			next_state.framing_error_flag = 1'b0; // RQ8
			next_state.parity_error_flag = 1'b0; // RQ8
			next_state.rx = uart_rx_pkg::RX_IDLE;
			next_state.pend_valid = 1'b0;
			next_state.data_valid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= '0;
			state.rx <= uart_rx_pkg::RX_IDLE;
			state.baud <= `BAUD_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_cts_live;
		@(posedge ref_clk) disable iff (!rst_b)
		(status_rd && flow_en) |=> (reg_rdata[3] == $past(cts_level));
	endproperty
	a_cts_live: assert property (p_cts_live) // RQ1
		else $error("CTS status bit does not follow the pin");

	property p_cts_no_store;
		@(posedge ref_clk) disable iff (!rst_b)
		(status_rd && !(flow_en && cts_level)) |=> !reg_rdata[3];
	endproperty
	a_cts_no_store: assert property (p_cts_no_store) // RQ2
		else $error("CTS status bit took a written value");

	property p_overflow_set;
		@(posedge ref_clk) disable iff (!rst_b)
		(start_det && state.pend_valid && !fifo.push_ready) |=>
			state.receive_overflow_flag;
	endproperty
	a_overflow_set: assert property (p_overflow_set) // RQ3
		else $error("Overflow not flagged");

	property p_frame_err;
		@(posedge ref_clk) disable iff (!rst_b)
		(stop_take && !rx_level) |=>
			(state.pend_valid && state.pend.frame_bad);
	endproperty
	a_frame_err: assert property (p_frame_err) // RQ4
		else $error("Low stop bit not marked as framing error");

	property p_parity_only_enabled;
		@(posedge ref_clk) disable iff (!rst_b)
		(stop_take && !parity_en) |=> !state.pend.parity_bad;
	endproperty
	a_parity_only_enabled: assert property (p_parity_only_enabled) // RQ5
		else $error("Parity error without parity format");

	property p_clear_one;
		@(posedge ref_clk) disable iff (!rst_b)
		(status_wr && reg_wdata[2] && !ovf_set) |=>
			!state.receive_overflow_flag;
	endproperty
	a_clear_one: assert property (p_clear_one) // RQ6
		else $error("Writing one did not clear overflow");

	property p_zero_keeps;
		@(posedge ref_clk) disable iff (!rst_b)
		(status_wr && (reg_wdata[2:0] == 3'h0) && state.rx_enable) |=>
			((err_flags & $past(err_flags)) == $past(err_flags));
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) // RQ7
		else $error("Writing zero changed an error flag");

	property p_disable_clears;
		@(posedge ref_clk) disable iff (!rst_b)
		!state.rx_enable |=> (err_flags == 3'h0);
	endproperty
	a_disable_clears: assert property (p_disable_clears) // RQ8
		else $error("Error flags survive receiver disable");

	property p_flag_follows_char;
		@(posedge ref_clk) disable iff (!rst_b)
		(load && head.frame_bad) |=>
			(state.framing_error_flag && state.data_valid);
	endproperty
	a_flag_follows_char: assert property (p_flag_follows_char) // RQ9
		else $error("Framing flag missing for next character");

	property p_char_with_marks;
		@(posedge ref_clk) disable iff (!rst_b)
		load |=> (state.dreg == $past(head));
	endproperty
	a_char_with_marks: assert property (p_char_with_marks) // RQ10
		else $error("Data register lost its error marks");
endmodule
`default_nettype wire

// ### tb/serial_tx_model.sv
// Purpose: Remote serial transmitter with a clear-to-send output.
// Assumes: One bit lasts BIT cycles of ref_clk.
// Notes:   Faults in parity or stop bit only when a call asks for them.
`timescale 1ns/1ns
`default_nettype none
module serial_tx_model #(
	parameter int BIT = 8 // Cycles per bit
) (
	input wire logic ref_clk,
	output logic line,
	output logic cts_pin
);
	// ****************************************************************
	// Line drive
	// ****************************************************************
	// Idle line high, flow control input low
	initial begin
		line = 1'b1;
		cts_pin = 1'b0;
	end

	// One bit held for a full bit time, changed after an edge
	task automatic bit_out(input logic v);
		line <= v;
		repeat (BIT) @(posedge ref_clk);
	endtask

	// Flow control level, the only driver of that pin
	task automatic set_cts(input logic v);
		cts_pin <= v;
	endtask

	// Whole frame: start, data LSB first, optional parity, stop, idle
	task automatic send(input logic [7:0] d, input logic pe,
		input logic odd, input logic bad_par, input logic bad_stop);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++) begin
			bit_out(d[i]);
		end
		// Parity bit only for parity formats, flipped on request
		if (pe) begin
			bit_out(^d ^ odd ^ bad_par);
		end
		bit_out(~bad_stop);
		bit_out(1'b1);
		bit_out(1'b1);
	endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench of the receive status block.
// Assumes: Bit time set to 8 cycles through the baud register.
// Notes:   Waits after frames cover sync and buffer latency.
`timescale 1ns/1ns
`default_nettype none
`include "uart_rx_regs.svh"
module tb;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic ref_clk; // Bench clock
	logic rst_b; // Active low reset
	wire logic rx_line; // Serial line from the model
	wire logic cts_line; // Flow control level from the model
	logic [3:0] reg_addr; // Register index
	logic [15:0] reg_wdata; // Write data
	logic reg_wr; // Write strobe
	logic reg_rd; // Read strobe
	logic [15:0] reg_rdata; // Read data
	logic [15:0] rd_val; // Last value read
	int error_cnt; // Mismatches
	int n_tests; // Comparisons

	uart_rx_error_status i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.rx_pin(rx_line), .cts_pin(cts_line), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	serial_tx_model #(.BIT(8)) i_tx (.ref_clk(ref_clk), .line(rx_line),
		.cts_pin(cts_line));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	// One-cycle write
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read, data taken in the following cycle
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Read and compare
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		rd(a);
		check(rd_val, exp);
	endtask

	// Receiver on with format, pinout and parity sense
	task automatic cfg(input logic [3:0] f, input logic [1:0] po,
		input logic odd);
		wr(`CTRL_OFS, {8'h00, odd, po, f, 1'b1});
	endtask

	// Verdict and end of run
	task automatic results();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Clock, reset and watchdog
	// ****************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Cuts a hang short
	initial begin
		repeat (50000) @(posedge ref_clk);
		error_cnt++;
		results();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic pe;
		rst_b = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		error_cnt = 0;
		n_tests = 0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		// Reset values, unmapped index
		rchk(`BAUD_OFS, `BAUD_RESET);
		rchk(`STATUS_OFS, 16'h0000);
		rchk(4'hF, 16'h0000);
		wr(`BAUD_OFS, 16'h0008);
		// Clear-to-send hidden without flow control
		i_tx.set_cts(1'b1);
		cfg(4'h0, 2'h0, 1'b0);
		repeat (6) @(posedge ref_clk);
		rchk(`STATUS_OFS, 16'h0000);
		// Clear-to-send follows the pin under flow control
		cfg(4'h0, `PINOUT_FLOW, 1'b0);
		repeat (6) @(posedge ref_clk);
		rchk(`STATUS_OFS, 16'h0008);
		wr(`STATUS_OFS, 16'h0008);
		rchk(`STATUS_OFS, 16'h0008);
		// Writing one over a low pin must not raise the bit
		i_tx.set_cts(1'b0);
		repeat (6) @(posedge ref_clk);
		wr(`STATUS_OFS, 16'h0008);
		rchk(`STATUS_OFS, 16'h0000);
		// Framing error, then write zero and write one
		cfg(4'h0, 2'h0, 1'b0);
		i_tx.send(8'h3C, 1'b0, 1'b0, 1'b0, 1'b1);
		rchk(`STATUS_OFS, 16'h0012);
		rchk(`DATA_OFS, 16'h003C);
		wr(`STATUS_OFS, 16'h0000);
		rchk(`STATUS_OFS, 16'h0002);
		wr(`STATUS_OFS, 16'h0002);
		rchk(`STATUS_OFS, 16'h0000);
		// Every format, bad parity sent only on parity formats, which flag it
		for (int f = 0; f < 16; f++) begin
			pe = (f == 1 || f == 5 || f == 7);
			cfg(f[3:0], 2'h0, 1'b0);
			i_tx.send(8'hA5 ^ 8'(f), pe, 1'b0, pe, 1'b0);
			rchk(`STATUS_OFS, pe ? 16'h0011 : 16'h0010);
			rchk(`DATA_OFS, {8'h00, 8'hA5 ^ 8'(f)});
			wr(`STATUS_OFS, 16'h0007);
		end
		// Good odd parity raises nothing
		cfg(`FORM_PAR_B, 2'h0, 1'b1);
		i_tx.send(8'h81, 1'b1, 1'b1, 1'b0, 1'b0);
		rchk(`STATUS_OFS, 16'h0010);
		rchk(`DATA_OFS, 16'h0081);
		// Errors ride with their own character
		cfg(4'h0, 2'h0, 1'b0);
		i_tx.send(8'h11, 1'b0, 1'b0, 1'b0, 1'b0);
		i_tx.send(8'h22, 1'b0, 1'b0, 1'b0, 1'b1);
		rchk(`STATUS_OFS, 16'h0010);
		rchk(`DATA_OFS, 16'h0011);
		repeat (4) @(posedge ref_clk);
		rchk(`STATUS_OFS, 16'h0012);
		rchk(`DATA_OFS, 16'h0022);
		wr(`STATUS_OFS, 16'h0007);
		// Ten characters fill every stage, the eleventh overflows
		for (int i = 0; i < 11; i++) begin
			i_tx.send(8'h40 + 8'(i), 1'b0, 1'b0, 1'b0, 1'b0);
			if (i == 9) begin
				rchk(`STATUS_OFS, 16'h0010);
			end
		end
		rchk(`STATUS_OFS, 16'h0014);
		rchk(`DATA_OFS, 16'h0040);
		// Disabling the receiver clears all error flags
		wr(`CTRL_OFS, 16'h0000);
		rchk(`STATUS_OFS, 16'h0000);
		results();
	end
endmodule
`default_nettype wire
